// ===== common/bpdbg_defs.svh
// Register indices, field positions, reset values and constants of
// the break point and debug control block.
// Assumes a byte bus address of four times the register index.
`ifndef BPDBG_DEFS_SVH
`define BPDBG_DEFS_SVH

`define BPDBG_IDX_LAST_LOW   16'ha098
`define BPDBG_IDX_LAST_HIGH  16'ha099
`define BPDBG_IDX_LAST_TOP   16'ha09a
`define BPDBG_IDX_NEXT_LOW   16'ha09b
`define BPDBG_IDX_NEXT_HIGH  16'ha09c
`define BPDBG_IDX_NEXT_TOP   16'ha09d
`define BPDBG_IDX_STEP_KEY   16'ha09e
`define BPDBG_IDX_FLAGS      16'ha0e0
`define BPDBG_IDX_ENABLES    16'ha0e1
`define BPDBG_IDX_CTRL       16'ha0e3
`define BPDBG_IDX_ONE_LOW    16'ha0f0
`define BPDBG_IDX_ONE_HIGH   16'ha0f1
`define BPDBG_IDX_ONE_TOP    16'ha0f2
`define BPDBG_IDX_TWO_LOW    16'ha0f4
`define BPDBG_IDX_TWO_HIGH   16'ha0f5
`define BPDBG_IDX_TWO_TOP    16'ha0f6

`define BPDBG_CTRL_IRQ_REEN  7
`define BPDBG_CTRL_WDT_EN    6
`define BPDBG_CTRL_T2_EN     5
`define BPDBG_CTRL_T0_EN     3
`define BPDBG_CTRL_IN_RTN    0
`define BPDBG_CTRL_RESET     8'hfc
`define BPDBG_CTRL_FIXED     8'h06
`define BPDBG_FLAG_STEP      7
`define BPDBG_FLAG_MASK      8'h83
`define BPDBG_STEP_KEY       8'h96
`define BPDBG_VEC_BREAK      16'h7080
`define BPDBG_VEC_DEBUG      16'h70c0

`endif

// ===== common/bpdbg_pkg.sv
// Types shared by the break point and debug control block.
// Assumes the constants header is included where numbers are needed.
package bpdbg_pkg;
	typedef enum logic {BPDBG_BUS_IDLE, BPDBG_BUS_DONE} bpdbg_bus_state_t;
	typedef logic [1:0][23:0] bpdbg_addr_pair_t;
endpackage : bpdbg_pkg

// ===== common/bpdbg_reg_if.sv
// Register access carrier between the bus slave and the register file.
// Assumes one clock; strobe and data are sampled on its rising edge.
`timescale 1ns/1ps
interface bpdbg_reg_if;
	logic        wr;
	logic [15:0] index;
	logic [7:0]  wdata;
	logic [7:0]  rdata;
	modport bus_side (output wr, output index, output wdata, input rdata);
	modport reg_side (input wr, input index, input wdata, output rdata);
endinterface : bpdbg_reg_if

// ===== src/bpdbg_match.sv
// Program counter comparators of the two break points.
// Assumes fetch address and valid are synchronous to the core clock.
`timescale 1ns/1ps
module bpdbg_match (
	input  wire logic                      i_fetch_valid,
	input  wire logic [23:0]               i_fetch_pc,
	input  wire bpdbg_pkg::bpdbg_addr_pair_t i_break_addr,
	output logic [1:0]                     o_hit
);
	// One full 24-bit compare per break point on every fetch.
	for (genvar g = 0; g < 2; g++) begin : g_cmp
		assign o_hit[g] = i_fetch_valid && (i_fetch_pc == i_break_addr[g]); // see [RQ24]
	end
endmodule : bpdbg_match

// ===== src/bpdbg_avs.sv
// Avalon-MM slave front end with one wait cycle per access.
// Assumes the master holds its request until waitrequest is low.
`timescale 1ns/1ps
module bpdbg_avs (
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst_n,
	input  wire logic [17:0] i_avs_address,
	input  wire logic [3:0]  i_avs_byteenable,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	output logic [31:0]      o_avs_readdata,
	output logic             o_avs_waitrequest,
	bpdbg_reg_if.bus_side    rif
);
	bpdbg_pkg::bpdbg_bus_state_t state;
	bpdbg_pkg::bpdbg_bus_state_t next_state;
	logic [7:0]                  rdata;
	logic [7:0]                  next_rdata;

	// Byte lane zero carries the register; the write lands at the last edge.
	assign rif.index       = i_avs_address[17:2];
	assign rif.wdata       = i_avs_writedata[7:0];
	assign rif.wr          = i_avs_write && i_avs_byteenable[0] && (state == bpdbg_pkg::BPDBG_BUS_DONE);
	assign o_avs_readdata  = {24'h000000, rdata};
	assign o_avs_waitrequest = (i_avs_read || i_avs_write) && (state != bpdbg_pkg::BPDBG_BUS_DONE);

	// Read data is taken in the wait cycle and stands in the answer cycle.
	always_comb begin
		next_state = state;
		next_rdata = rdata;
		case (state)
			bpdbg_pkg::BPDBG_BUS_IDLE: begin
				if (i_avs_read || i_avs_write) begin
					next_state = bpdbg_pkg::BPDBG_BUS_DONE;
					next_rdata = rif.rdata;
				end
			end
			bpdbg_pkg::BPDBG_BUS_DONE: next_state = bpdbg_pkg::BPDBG_BUS_IDLE;
			default: next_state = bpdbg_pkg::BPDBG_BUS_IDLE;
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			state <= bpdbg_pkg::BPDBG_BUS_IDLE;
			rdata <= 8'h00;
		end else begin
			state <= next_state;
			rdata <= next_rdata;
		end
	end
endmodule : bpdbg_avs

// ===== src/bpdbg_top.sv
// Break point and debug control block: PC compare, single-step key,
// routine suspend control, PC capture and interrupt request to the core.
// Assumes the core pulses i_irq_ack when it enters the vector shown.
//
// Contract
// [RQ1] Entering debug or break routine suspends interrupts and gated counters.
// [RQ2] Hardware clears suspend enable bits at routine entry.
// [RQ3] Software enables a needed timer after routine entry.
// [RQ4] Software should set counting enables before leaving the routine.
// [RQ5] Software writes suspend control only inside the debug routine.
// [RQ6] Control bit 7 re-enables all but watchdog interrupt in routine.
// [RQ7] Control bit 7 clears automatically at every routine entry.
// [RQ8] With bit 7 set the routine can be interrupted.
// [RQ9] Control bit 6 gates watchdog counting during the routine.
// [RQ10] Bits 5, 4, 3 gate timers two, one, zero counting only.
// [RQ11] Control bit 0 is set at routine entry.
// [RQ12] Software clears bit 0 on leaving; others read it for nesting.
// [RQ13] Control resets to 0xfc; bits 2 and 1 unused.
// [RQ14] Break one compares PC with its 24-bit three-byte value.
// [RQ15] Break two compares PC with its own 24-bit three-byte value.
// [RQ16] On a break, capture the just executed address, read-only.
// [RQ17] On a break, capture the next PC address, read-only.
// [RQ18] Single stepping is armed only by key value 0x96.
// [RQ19] Match flags are set by hardware and stay until cleared.
// [RQ20] Single-step event fires on a fetch after interrupt return.
// [RQ21] Break match raises the break interrupt at vector 0x7080.
// [RQ22] Debug request vectors to 0x70c0 with highest priority.
// [RQ23] Break interrupt only when a flag and its enable are set.
// [RQ24] PC compare runs on every fetch across all 24 bits.
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "bpdbg_defs.svh"
module bpdbg_top (
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst_n,
	input  wire logic [17:0] i_avs_address,
	input  wire logic [3:0]  i_avs_byteenable,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	output logic [31:0]      o_avs_readdata,
	output logic             o_avs_waitrequest,
	input  wire logic        i_fetch_valid,
	input  wire logic [23:0] i_fetch_pc,
	input  wire logic [23:0] i_exec_pc,
	input  wire logic        i_reti_fetch,
	input  wire logic        i_host_debug_request,
	input  wire logic        i_irq_ack,
	output logic             o_irq_req,
	output logic [15:0]      o_irq_vector,
	output logic             o_irq_enable,
	output logic             o_wdt_irq_enable,
	output logic             o_wdt_count_en,
	output logic [2:0]       o_timer_count_en,
	output logic             o_in_debug_routine,
	output logic             o_single_step_enabled
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------

	logic [7:0]  debug_suspend_control;
	logic [7:0]  next_debug_suspend_control;
	logic [7:0]  break_flags;
	logic [7:0]  next_break_flags;
	logic [7:0]  break_enables;
	logic [7:0]  next_break_enables;
	logic [7:0]  single_step_key;
	logic [7:0]  next_single_step_key;
	logic [23:0] break_one_addr;
	logic [23:0] next_break_one_addr;
	logic [23:0] break_two_addr;
	logic [23:0] next_break_two_addr;
	logic [23:0] last_pc_capture;
	logic [23:0] next_last_pc_capture;
	logic [23:0] next_pc_capture;
	logic [23:0] next_next_pc_capture;
	logic        dbg_pending;
	logic        next_dbg_pending;

	logic [1:0]  hit;
	logic        step_event;
	logic [7:0]  flag_set;
	logic        in_routine;
	logic        break_req;

	bpdbg_reg_if rif ();

	// ------------------------------------------------------------
	// Bus slave and comparators
	// ------------------------------------------------------------

	// Avalon-MM front end; one wait cycle, then the answer.
	bpdbg_avs u_avs (
		.i_sys_clk        (i_sys_clk),
		.i_rst_n          (i_rst_n),
		.i_avs_address    (i_avs_address),
		.i_avs_byteenable (i_avs_byteenable),
		.i_avs_read       (i_avs_read),
		.i_avs_write      (i_avs_write),
		.i_avs_writedata  (i_avs_writedata),
		.o_avs_readdata   (o_avs_readdata),
		.o_avs_waitrequest(o_avs_waitrequest),
		.rif              (rif.bus_side)
	);

	// Both compare values are assembled from their three bytes.
	bpdbg_match u_match (
		.i_fetch_valid(i_fetch_valid),
		.i_fetch_pc   (i_fetch_pc),
		.i_break_addr ({break_two_addr, break_one_addr}), // see [RQ14] see [RQ15]
		.o_hit        (hit)
	);

	// ------------------------------------------------------------
	// Events and core-facing controls
	// ------------------------------------------------------------

	// Single step fires only with the key armed and after a return.
	assign o_single_step_enabled = (single_step_key == `BPDBG_STEP_KEY); // see [RQ18]
	assign step_event = o_single_step_enabled && i_fetch_valid && i_reti_fetch; // see [RQ20]
	assign flag_set   = {step_event, 5'h00, hit};

	// Suspension applies only while the routine status bit is set.
	assign in_routine         = debug_suspend_control[`BPDBG_CTRL_IN_RTN];
	assign o_in_debug_routine = in_routine;
	assign o_irq_enable       = !in_routine || debug_suspend_control[`BPDBG_CTRL_IRQ_REEN]; // see [RQ1] see [RQ6]
	assign o_wdt_irq_enable   = !in_routine; // see [RQ6]
	assign o_wdt_count_en     = !in_routine || debug_suspend_control[`BPDBG_CTRL_WDT_EN]; // see [RQ9]

	// Only counting is gated; timer interrupt enables are untouched.
	always_comb begin
		for (int t = 0; t < 3; t++) begin
			o_timer_count_en[t] = !in_routine || debug_suspend_control[`BPDBG_CTRL_T0_EN + t]; // see [RQ10]
		end
	end

	// A debug request outranks a break and is never masked.
	assign break_req    = |(break_flags & break_enables & `BPDBG_FLAG_MASK); // see [RQ23]
	assign o_irq_req    = dbg_pending || (break_req && o_irq_enable); // see [RQ8] see [RQ21]
	assign o_irq_vector = dbg_pending ? `BPDBG_VEC_DEBUG : `BPDBG_VEC_BREAK; // see [RQ22]

	// ------------------------------------------------------------
	// Register read mux
	// ------------------------------------------------------------

	// Unmapped indices read as zero.
	always_comb begin
		case (rif.index)
			`BPDBG_IDX_LAST_LOW:  rif.rdata = last_pc_capture[7:0];
			`BPDBG_IDX_LAST_HIGH: rif.rdata = last_pc_capture[15:8];
			`BPDBG_IDX_LAST_TOP:  rif.rdata = last_pc_capture[23:16];
			`BPDBG_IDX_NEXT_LOW:  rif.rdata = next_pc_capture[7:0];
			`BPDBG_IDX_NEXT_HIGH: rif.rdata = next_pc_capture[15:8];
			`BPDBG_IDX_NEXT_TOP:  rif.rdata = next_pc_capture[23:16];
			`BPDBG_IDX_STEP_KEY:  rif.rdata = single_step_key;
			`BPDBG_IDX_FLAGS:     rif.rdata = break_flags;
			`BPDBG_IDX_ENABLES:   rif.rdata = break_enables;
			`BPDBG_IDX_CTRL:      rif.rdata = debug_suspend_control;
			`BPDBG_IDX_ONE_LOW:   rif.rdata = break_one_addr[7:0];
			`BPDBG_IDX_ONE_HIGH:  rif.rdata = break_one_addr[15:8];
			`BPDBG_IDX_ONE_TOP:   rif.rdata = break_one_addr[23:16];
			`BPDBG_IDX_TWO_LOW:   rif.rdata = break_two_addr[7:0];
			`BPDBG_IDX_TWO_HIGH:  rif.rdata = break_two_addr[15:8];
			`BPDBG_IDX_TWO_TOP:   rif.rdata = break_two_addr[23:16];
			default:              rif.rdata = 8'h00;
		endcase
	end

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------

	// Software writes first, then hardware events override them.
	always_comb begin
		next_debug_suspend_control = debug_suspend_control;
		next_break_flags           = break_flags;
		next_break_enables         = break_enables;
		next_single_step_key       = single_step_key;
		next_break_one_addr        = break_one_addr;
		next_break_two_addr        = break_two_addr;
		next_last_pc_capture       = last_pc_capture;
		next_next_pc_capture       = next_pc_capture;
		next_dbg_pending           = dbg_pending;
		if (rif.wr) begin
			case (rif.index)
				`BPDBG_IDX_STEP_KEY:  next_single_step_key = rif.wdata;
				`BPDBG_IDX_FLAGS:     next_break_flags = break_flags & ~(rif.wdata & `BPDBG_FLAG_MASK);
				`BPDBG_IDX_ENABLES:   next_break_enables = rif.wdata & `BPDBG_FLAG_MASK;
				`BPDBG_IDX_CTRL:      next_debug_suspend_control = (rif.wdata & ~`BPDBG_CTRL_FIXED)
						| (`BPDBG_CTRL_RESET & `BPDBG_CTRL_FIXED); // see [RQ13]
				`BPDBG_IDX_ONE_LOW:   next_break_one_addr[7:0] = rif.wdata;
				`BPDBG_IDX_ONE_HIGH:  next_break_one_addr[15:8] = rif.wdata;
				`BPDBG_IDX_ONE_TOP:   next_break_one_addr[23:16] = rif.wdata;
				`BPDBG_IDX_TWO_LOW:   next_break_two_addr[7:0] = rif.wdata;
				`BPDBG_IDX_TWO_HIGH:  next_break_two_addr[15:8] = rif.wdata;
				`BPDBG_IDX_TWO_TOP:   next_break_two_addr[23:16] = rif.wdata;
				default:              next_break_flags = break_flags;
			endcase
		end
		// A new event wins over a clear in the same cycle.
		next_break_flags = next_break_flags | flag_set; // see [RQ19]
		// Both program counters are latched on any break event.
		if (|flag_set) begin
			next_last_pc_capture = i_exec_pc; // see [RQ16]
			next_next_pc_capture = i_fetch_pc; // see [RQ17]
		end
		// Routine entry: suspend everything and mark the routine.
		if (i_irq_ack) begin
			next_debug_suspend_control[7:3] = 5'h00; // see [RQ2] see [RQ7]
			next_debug_suspend_control[`BPDBG_CTRL_IN_RTN] = 1'b1; // see [RQ11]
		end
		// The debug request stays pending until its vector is taken.
		if (i_irq_ack && dbg_pending) begin
			next_dbg_pending = 1'b0;
		end
		if (i_host_debug_request) begin
			next_dbg_pending = 1'b1; // see [RQ22]
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------

	// The synchronous system reset loads control with 0xfc and clears all other state.
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			debug_suspend_control <= `BPDBG_CTRL_RESET; // see [RQ13]
			break_flags           <= 8'h00;
			break_enables         <= 8'h00;
			single_step_key       <= 8'h00;
			break_one_addr        <= 24'h000000;
			break_two_addr        <= 24'h000000;
			last_pc_capture       <= 24'h000000;
			next_pc_capture       <= 24'h000000;
			dbg_pending           <= 1'b0;
		end else begin
			debug_suspend_control <= next_debug_suspend_control;
			break_flags           <= next_break_flags;
			break_enables         <= next_break_enables;
			single_step_key       <= next_single_step_key;
			break_one_addr        <= next_break_one_addr;
			break_two_addr        <= next_break_two_addr;
			last_pc_capture       <= next_last_pc_capture;
			next_pc_capture       <= next_next_pc_capture;
			dbg_pending           <= next_dbg_pending;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);

	// Entry clears the enables and marks the routine.
	entry_suspend_a: assert property ( // see [RQ2]
		i_irq_ack |=> (debug_suspend_control[7:3] == 5'h00) && in_routine
			&& !o_wdt_count_en && (o_timer_count_en == 3'h0) && !o_irq_enable)
		else $error("routine entry did not suspend");

	// The re-enable bit is cleared on entry even if just written.
	reen_clear_a: assert property ( // see [RQ7]
		i_irq_ack && rif.wr && (rif.index == `BPDBG_IDX_CTRL) |=> !debug_suspend_control[7])
		else $error("re-enable bit survived entry");

	// Watchdog counting follows bit 6 inside the routine.
	wdt_gate_a: assert property ( // see [RQ9]
		in_routine |-> (o_wdt_count_en == debug_suspend_control[6]))
		else $error("watchdog gate wrong");

	// Timer two counting follows bit 5 inside the routine.
	timer_gate_a: assert property ( // see [RQ10]
		in_routine |-> (o_timer_count_en[2] == debug_suspend_control[5]))
		else $error("timer two gate wrong");

	// The watchdog interrupt stays blocked even with re-enable set.
	irq_reen_a: assert property ( // see [RQ6]
		in_routine && debug_suspend_control[7] |-> o_irq_enable && !o_wdt_irq_enable)
		else $error("interrupt re-enable wrong");

	// Control comes out of reset at its documented value.
	ctrl_reset_a: assert property ( // see [RQ13]
		$rose(i_rst_n) |-> (debug_suspend_control == 8'hfc))
		else $error("control reset value wrong");

	// A match on break one sets its flag and both captures.
	match_one_a: assert property ( // see [RQ14]
		i_fetch_valid && (i_fetch_pc == break_one_addr) |=> break_flags[0]
			&& (last_pc_capture == $past(i_exec_pc)) && (next_pc_capture == $past(i_fetch_pc)))
		else $error("break one match not recorded");

	// The break two flag holds unless software writes a one to it.
	flag_sticky_a: assert property ( // see [RQ19]
		break_flags[1] && !(rif.wr && (rif.index == `BPDBG_IDX_FLAGS) && rif.wdata[1]) |=> break_flags[1])
		else $error("break two flag lost");

	// No step event without the exact key.
	step_key_a: assert property ( // see [RQ18]
		!break_flags[`BPDBG_FLAG_STEP] && (single_step_key != 8'h96) |=> !break_flags[`BPDBG_FLAG_STEP])
		else $error("step flag set without key");

	// The break request needs a flag paired with its enable.
	break_req_a: assert property ( // see [RQ23]
		o_irq_req && (o_irq_vector == 16'h7080) |-> |(break_flags & break_enables))
		else $error("break request without enable");

	// A debug request presents the debug vector the next cycle.
	dbg_prio_a: assert property ( // see [RQ22]
		i_host_debug_request |=> o_irq_req && (o_irq_vector == 16'h70c0))
		else $error("debug request not first");

endmodule : bpdbg_top

// ===== dv/bpdbg_core_model.sv
// Behavioural core model: fetch stream, executed address and interrupt acknowledge.
// Assumes bench commands change just after rising edges of the one system clock.
`timescale 1ns/1ps
module bpdbg_core_model #(
	parameter int ACK_DELAY = 0
) (
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_cmd_fetch,
	input  wire logic [23:0] i_cmd_pc,
	input  wire logic        i_cmd_reti,
	input  wire logic        i_ack_en,
	input  wire logic        i_irq_req,
	output logic             o_fetch_valid,
	output logic [23:0]      o_fetch_pc,
	output logic [23:0]      o_exec_pc,
	output logic             o_reti_fetch,
	output logic             o_irq_ack
);
	logic [23:0] last_pc;
	int          wait_cnt;

	// One fetch per command; an idle address bus toggles so stale values never match.
	always_ff @(posedge i_sys_clk) begin
		o_fetch_valid <= i_cmd_fetch && i_rst_n;
		o_fetch_pc    <= i_cmd_fetch ? i_cmd_pc : ~o_fetch_pc;
		o_reti_fetch  <= i_cmd_fetch && i_cmd_reti;
		if (i_cmd_fetch) begin
			o_exec_pc <= last_pc;
			last_pc   <= i_cmd_pc;
		end
	end

	// Acknowledge a held request after ACK_DELAY cycles, as a one-cycle pulse.
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n || !i_irq_req || !i_ack_en || o_irq_ack) begin
			o_irq_ack <= 1'b0;
			wait_cnt  <= 0;
		end else if (wait_cnt >= ACK_DELAY) begin
			o_irq_ack <= 1'b1;
		end else begin
			wait_cnt <= wait_cnt + 1;
		end
	end
endmodule : bpdbg_core_model

// ===== dv/bpdbg_top_tb_top.sv
// Self-checking bench of the break point and debug control block.
// Assumes the core model answers interrupts only while the bench allows it.
`timescale 1ns/1ps
`include "bpdbg_defs.svh"
module bpdbg_top_tb_top;
	typedef struct packed {logic wr; logic [15:0] idx; logic [7:0] d; logic [7:0] exp;} bpdbg_row_t;
	logic        clk, rst_n, rd, wr, cf, cr, ack_en, dbg, fv, rf, ack, irq, ien, wien, wcnt, indbg, step;
	logic [17:0] adr;
	logic [31:0] wd, rdat;
	logic        wreq;
	logic [23:0] cpc, fpc, epc;
	logic [15:0] vec;
	logic [2:0]  tcnt;
	int          bad_count, n_compared;
	bpdbg_row_t  rows [12] = '{'{1'b0, 16'ha0e3, 8'h00, 8'hfc}, '{1'b0, 16'ha0e0, 8'h00, 8'h00},
		'{1'b0, 16'ha0e1, 8'h00, 8'h00}, '{1'b1, 16'ha0f0, 8'h56, 8'h56}, '{1'b1, 16'ha0f1, 8'h34, 8'h34},
		'{1'b1, 16'ha0f2, 8'h12, 8'h12}, '{1'b1, 16'ha0f4, 8'haa, 8'haa}, '{1'b1, 16'ha0f5, 8'hbb, 8'hbb},
		'{1'b1, 16'ha0f6, 8'hcc, 8'hcc}, '{1'b1, 16'ha09a, 8'hff, 8'h00}, '{1'b1, 16'ha0e2, 8'hff, 8'h00},
		'{1'b1, 16'ha0e3, 8'h7a, 8'h7c}};

	bpdbg_top bpdbg_top_i (.i_sys_clk(clk), .i_rst_n(rst_n), .i_avs_address(adr), .i_avs_byteenable(4'h1),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdat),
		.o_avs_waitrequest(wreq), .i_fetch_valid(fv), .i_fetch_pc(fpc), .i_exec_pc(epc), .i_reti_fetch(rf),
		.i_host_debug_request(dbg), .i_irq_ack(ack), .o_irq_req(irq), .o_irq_vector(vec), .o_irq_enable(ien),
		.o_wdt_irq_enable(wien), .o_wdt_count_en(wcnt), .o_timer_count_en(tcnt),
		.o_in_debug_routine(indbg), .o_single_step_enabled(step));
	bpdbg_core_model #(.ACK_DELAY(2)) bpdbg_core_model_i (.i_sys_clk(clk), .i_rst_n(rst_n), .i_cmd_fetch(cf),
		.i_cmd_pc(cpc), .i_cmd_reti(cr), .i_ack_en(ack_en), .i_irq_req(irq), .o_fetch_valid(fv),
		.o_fetch_pc(fpc), .o_exec_pc(epc), .o_reti_fetch(rf), .o_irq_ack(ack));

	// -----------------------------------------------------------------
	// Helpers
	// -----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// One Avalon access, held until waitrequest is sampled low.
	// Only the watchdog ends a wait whose answer never comes.
	task automatic bus(input logic w, input logic [15:0] idx, input logic [7:0] d, output logic [31:0] q);
		@(posedge clk);
		adr <= {idx, 2'b00};
		wd  <= {24'h0, d};
		wr  <= w;
		rd  <= !w;
		do begin
			@(posedge clk);
		end while (wreq !== 1'b0);
		q  = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask : bus
	task automatic wreg(input logic [15:0] idx, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, idx, d, q);
	endtask : wreg
	task automatic rchk(input logic [15:0] idx, input logic [7:0] exp);
		logic [31:0] q;
		bus(1'b0, idx, 8'h00, q);
		chk(q, {24'h0, exp});
	endtask : rchk
	// Compares the core-facing levels once the last update has landed.
	task automatic pchk(input logic [8:0] exp);
		@(posedge clk);
		chk({23'h0, irq, ien, wien, wcnt, tcnt, indbg, step}, {23'h0, exp});
	endtask : pchk
	task automatic fetch(input logic [23:0] pc, input logic reti);
		@(posedge clk);
		cf  <= 1'b1;
		cpc <= pc;
		cr  <= reti;
		@(posedge clk);
		cf <= 1'b0;
		repeat (2) @(posedge clk);
	endtask : fetch
	// Lets the core model take one interrupt; the watchdog ends a missing one.
	task automatic enter();
		ack_en <= 1'b1;
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		ack_en <= 1'b0;
	endtask : enter
	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : print_verdict

	// -----------------------------------------------------------------
	// Clock, watchdog and tests
	// -----------------------------------------------------------------
	// Free-running system clock at 200 MHz.
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Ends a hung run with a counted mismatch.
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		print_verdict();
	end
	// Main sequence: table first, then the event scenarios.
	initial begin
		{rst_n, rd, wr, cf, cr, ack_en, dbg, adr, wd, cpc} = '0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		pchk(9'h0fc);
		for (int i = 0; i < 7; i++) rchk(16'ha098 + 16'(i), 8'h00);
		foreach (rows[i]) begin
			if (rows[i].wr) wreg(rows[i].idx, rows[i].d);
			rchk(rows[i].idx, rows[i].exp);
		end
		wreg(16'ha0e3, 8'hf8);
		$display("register table done");
		wreg(`BPDBG_IDX_ENABLES, 8'h01);
		fetch(24'h923456, 1'b0);
		rchk(`BPDBG_IDX_FLAGS, 8'h00);
		fetch(24'h123453, 1'b0);
		fetch(24'h123456, 1'b0);
		chk({15'h0, irq, vec}, {15'h1, 16'h7080});
		rchk(`BPDBG_IDX_FLAGS, 8'h01);
		for (int i = 0; i < 3; i++) rchk(16'ha098 + 16'(i), 8'(24'h123453 >> (8 * i)));
		for (int i = 0; i < 3; i++) rchk(16'ha09b + 16'(i), 8'(24'h123456 >> (8 * i)));
		enter();
		pchk(9'h002);
		rchk(`BPDBG_IDX_CTRL, 8'h05);
		wreg(`BPDBG_IDX_CTRL, 8'h49);
		pchk(9'h026);
		wreg(`BPDBG_IDX_CTRL, 8'hb1);
		pchk(9'h19a);
		wreg(`BPDBG_IDX_FLAGS, 8'h01);
		rchk(`BPDBG_IDX_FLAGS, 8'h00);
		wreg(`BPDBG_IDX_CTRL, 8'hf8);
		pchk(9'h0fc);
		$display("break one done");
		wreg(`BPDBG_IDX_ENABLES, 8'h02);
		fetch(24'hccbbaa, 1'b0);
		chk({15'h0, irq, vec}, {15'h1, 16'h7080});
		@(posedge clk);
		dbg <= 1'b1;
		@(posedge clk);
		dbg <= 1'b0;
		@(posedge clk);
		chk({15'h0, irq, vec}, {15'h1, 16'h70c0});
		enter();
		pchk(9'h002);
		chk({16'h0, vec}, {16'h0, 16'h7080});
		wreg(`BPDBG_IDX_CTRL, 8'h81);
		pchk(9'h182);
		// The acknowledge (two cycles of model delay) and a write of the re-enable bit land on one edge.
		ack_en <= 1'b1;
		@(posedge clk);
		wreg(`BPDBG_IDX_CTRL, 8'h81);
		ack_en <= 1'b0;
		rchk(`BPDBG_IDX_CTRL, 8'h05);
		wreg(`BPDBG_IDX_FLAGS, 8'h02);
		wreg(`BPDBG_IDX_CTRL, 8'hf8);
		$display("break two and debug request done");
		wreg(`BPDBG_IDX_ENABLES, 8'h80);
		fetch(24'hccbbaa, 1'b0);
		rchk(`BPDBG_IDX_FLAGS, 8'h02);
		pchk(9'h0fc);
		wreg(`BPDBG_IDX_FLAGS, 8'h02);
		wreg(`BPDBG_IDX_STEP_KEY, 8'h95);
		fetch(24'h000100, 1'b1);
		rchk(`BPDBG_IDX_FLAGS, 8'h00);
		wreg(`BPDBG_IDX_STEP_KEY, 8'h96);
		pchk(9'h0fd);
		fetch(24'h000200, 1'b1);
		rchk(`BPDBG_IDX_FLAGS, 8'h80);
		pchk(9'h1fd);
		$display("single step done");
		rst_n <= 1'b0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		rchk(`BPDBG_IDX_STEP_KEY, 8'h00);
		rchk(`BPDBG_IDX_CTRL, 8'hfc);
		pchk(9'h0fc);
		$display("second reset done");
		print_verdict();
	end
endmodule : bpdbg_top_tb_top
